// ===== verilog/amsp_pkg.sv
// Shared constants for the multilane serial port, both ends
package amsp_pkg;
  localparam int        RES_W      = 20;      // Output word width
  localparam int        CMD_W      = 20;      // Command word width
  localparam logic [4:0] MIN_CLKS  = 5'h14;   // Clocks for a valid write
  localparam int        LANES      = 4;       // Output lanes
  // Input protocol select codes
  localparam logic [1:0] PROTO_00  = 2'h0;
  localparam logic [1:0] PROTO_01  = 2'h1;
  localparam logic [1:0] PROTO_10  = 2'h2;
  localparam logic [1:0] PROTO_11  = 2'h3;
  // Output config field positions and codes
  localparam int        OC_MODE_LO = 0;
  localparam int        OC_LANE_LO = 2;
  localparam int        OC_CLK_LO  = 6;
  localparam logic [1:0] MODE_SPI  = 2'h0;
  localparam logic [1:0] MODE_SRC  = 2'h3;
  localparam logic [1:0] LANE_DUAL = 2'h2;
  localparam logic [1:0] LANE_QUAD = 2'h3;
  localparam logic [1:0] CLK_SCLK  = 2'h0;
  localparam logic [1:0] CLK_INT   = 2'h1;
  localparam logic [1:0] CLK_DIV2  = 2'h2;
  // Reset values
  localparam logic [7:0] ICFG_RST  = 8'h00;
  localparam logic [7:0] OCFG_RST  = 8'h00;
  // Command word layout: op, register address, data
  localparam int        CMD_OP_LO  = 16;
  localparam int        CMD_AD_LO  = 8;
  localparam logic [3:0] OP_WR     = 4'h1;
  localparam logic [7:0] REG_ICFG  = 8'h04;
  localparam logic [7:0] REG_OCFG  = 8'h08;
  // Host APB register byte addresses
  localparam logic [11:0] HA_CTRL  = 12'h000;
  localparam logic [11:0] HA_TX    = 12'h004;
  localparam logic [11:0] HA_RX    = 12'h008;
  localparam logic [11:0] HA_STAT  = 12'h00c;
  // Host control fields
  localparam int        HC_PROTO_LO = 0;
  localparam int        HC_LANE_LO  = 2;
  localparam int        HC_SRC      = 4;
  localparam int        HC_NCLK_LO  = 8;
  // Host serial clock half period
  localparam int        CLK_NS     = 8;
  localparam int        HALF_NS    = 32;
  localparam int        HALF_CYC   = (HALF_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ===== verilog/amsp_if.sv
// Pin-level link between host controller and converter port
interface amsp_if;
  logic       cs_n;              // Chip select, active low
  logic       sclk;              // Host serial clock
  logic       sdi;               // Serial data to device
  logic [3:0] sdo;               // Output lanes
  logic [3:0] sdo_oe;            // Lane drive enables
  logic       ready_strobe_out;  // Ready / strobe clock
  modport dev  (input cs_n, sclk, sdi, output sdo, sdo_oe, ready_strobe_out);
  modport host (output cs_n, sclk, sdi, input sdo, sdo_oe, ready_strobe_out);
endinterface

// ===== verilog/amsp_dev.sv
// Converter-side serial port: config writes, multilane and strobe read-out

module amsp_dev
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [19:0] result,
  output logic      [19:0] input_shift_word,
  output logic             cmd_valid,
  output logic      [7:0]  input_config_reg,
  output logic      [7:0]  output_config_reg,
  amsp_if.dev              link
);
  // Pin history for edge detection
  logic        cs_q, cs_d;
  logic        sclk_q, sclk_d;
  // Input path state
  logic [19:0] ish_q, ish_d;          // Raw input shift
  logic [4:0]  cnt_q, cnt_d;          // Saturating clock count
  logic [19:0] isw_q, isw_d;          // Accepted command word
  logic        cmdv_q, cmdv_d;        // Command pulse
  logic [7:0]  icfg_q, icfg_d;        // Input config
  logic [7:0]  ocfg_q, ocfg_d;        // Output config
  logic        hold_q, hold_d;        // Last captured input bit
  // Output path state
  logic [19:0] odr_q, odr_d;          // Output shift word
  logic [3:0]  sdo_q, sdo_d;          // Lane data
  logic [3:0]  oe_q, oe_d;            // Lane enables
  logic        first_q, first_d;      // Next launch shows MSB only
  logic        stb_q, stb_d;          // Ready / strobe level
  logic [2:0]  div_q, div_d;          // Internal clock divider
  // Decoded frame conditions
  logic        cs_fall, cs_rise, act;
  logic        s_rise, s_fall, cap_rise, cap, lau, launch;
  logic [1:0]  proto, omode, lanes, corg;
  logic        src, daisy, stb_sel;
  logic [3:0]  lane_mask;

  // Frame edges and sclk edges from sampled pins
  always_comb
  begin
    cs_fall  = cs_q & ~link.cs_n;
    cs_rise  = ~cs_q & link.cs_n;
    act      = ~cs_q & ~link.cs_n;
    s_rise   = link.sclk & ~sclk_q;
    s_fall   = ~link.sclk & sclk_q;
    proto    = icfg_q[1:0];
    omode    = ocfg_q[amsp_pkg::OC_MODE_LO +: 2];
    lanes    = ocfg_q[amsp_pkg::OC_LANE_LO +: 2];
    corg     = ocfg_q[amsp_pkg::OC_CLK_LO +: 2];
    src      = (omode == amsp_pkg::MODE_SRC);
    daisy    = (ocfg_q == amsp_pkg::OCFG_RST);
    cap_rise = (proto == amsp_pkg::PROTO_00) || (proto == amsp_pkg::PROTO_11);
    cap      = act & (cap_rise ? s_rise : s_fall);
    lau      = act & (cap_rise ? s_fall : s_rise);
  end

  // Pin history, input shift, clock count, command decode
  always_comb
  begin
    cs_d   = link.cs_n;
    sclk_d = link.sclk;
    ish_d  = ish_q;
    cnt_d  = cnt_q;
    isw_d  = isw_q;
    icfg_d = icfg_q;
    ocfg_d = ocfg_q;
    hold_d = hold_q;
    cmdv_d = 1'b0;
    // New frame restarts the count
    if (cs_fall)
    begin
      cnt_d = 5'h00;
    end
    if (cap)
    begin
      ish_d  = {ish_q[18:0], link.sdi};
      hold_d = link.sdi;
      cnt_d  = (cnt_q == amsp_pkg::MIN_CLKS) ? cnt_q : cnt_q + 5'h01;
    end
    if (cs_rise && (cnt_q >= amsp_pkg::MIN_CLKS))
    begin
      isw_d  = ish_q;
      cmdv_d = 1'b1;
      // New protocol applies from next frame
      if (ish_q[amsp_pkg::CMD_OP_LO +: 4] == amsp_pkg::OP_WR)
      begin
        if (ish_q[amsp_pkg::CMD_AD_LO +: 8] == amsp_pkg::REG_ICFG)
        begin
          icfg_d = {6'h00, ish_q[1:0]};
        end
        else if (ish_q[amsp_pkg::CMD_AD_LO +: 8] == amsp_pkg::REG_OCFG)
        begin
          ocfg_d = ish_q[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cs_q   <= 1'b1;
      sclk_q <= 1'b0;
      ish_q  <= 20'h00000;
      cnt_q  <= 5'h00;
      isw_q  <= 20'h00000;
      icfg_q <= amsp_pkg::ICFG_RST;
      ocfg_q <= amsp_pkg::OCFG_RST;
      hold_q <= 1'b0;
      cmdv_q <= 1'b0;
    end
    else
    begin
      cs_q   <= cs_d;
      sclk_q <= sclk_d;
      ish_q  <= ish_d;
      cnt_q  <= cnt_d;
      isw_q  <= isw_d;
      icfg_q <= icfg_d;
      ocfg_q <= ocfg_d;
      hold_q <= hold_d;
      cmdv_q <= cmdv_d;
    end
  end

  // Active lane mask from width field
  always_comb
  begin
    case (lanes)
      amsp_pkg::LANE_DUAL: lane_mask = 4'h3;
      amsp_pkg::LANE_QUAD: lane_mask = 4'hf;
      default:             lane_mask = 4'h1;
    endcase
    // Strobe source selection
    case (corg)
      amsp_pkg::CLK_SCLK: stb_sel = link.sclk;
      amsp_pkg::CLK_INT:  stb_sel = div_q[0];
      amsp_pkg::CLK_DIV2: stb_sel = div_q[1];
      default:            stb_sel = div_q[2];
    endcase
  end

  // Output word, lanes, strobe
  always_comb
  begin
    odr_d   = odr_q;
    oe_d    = oe_q;
    first_d = first_q;
    div_d   = act ? div_q + 3'h1 : 3'h0;
    stb_d   = 1'b1;
    launch  = 1'b0;
    if (act)
    begin
      stb_d  = 1'b0;
      if (src)
      begin
        stb_d  = stb_sel;
        launch = stb_sel & ~stb_q;
      end
      else
      begin
        launch = lau;
      end
    end
    if (cs_fall)
    begin
      odr_d   = result;
      oe_d    = lane_mask;
      stb_d   = 1'b0;
      div_d   = 3'h0;
      // Odd codes launch MSB on first edge
      first_d = src | proto[0];
    end
    else if (launch)
    begin
      if (first_q)
      begin
        first_d = 1'b0;
      end
      else
      begin
        // Shift by lane count, MSB first
        case (lanes)
          amsp_pkg::LANE_DUAL: odr_d = {odr_q[17:0], 2'h0};
          amsp_pkg::LANE_QUAD: odr_d = {odr_q[15:0], 4'h0};
          default:             odr_d = {odr_q[18:0], daisy & hold_q};
        endcase
      end
    end
    if (cs_rise)
    begin
      oe_d = 4'h0;
    end
  end

  // Lane data, lane 0 carries the MSB
  genvar gi;
  generate
    for (gi = 0; gi < amsp_pkg::LANES; gi++)
    begin : g_lane
      assign sdo_d[gi] = odr_d[amsp_pkg::RES_W - 1 - gi] & oe_d[gi];
    end
  endgenerate

  // Output path registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      odr_q   <= 20'h00000;
      sdo_q   <= 4'h0;
      oe_q    <= 4'h0;
      first_q <= 1'b0;
      stb_q   <= 1'b1;
      div_q   <= 3'h0;
    end
    else
    begin
      odr_q   <= odr_d;
      sdo_q   <= sdo_d;
      oe_q    <= oe_d;
      first_q <= first_d;
      stb_q   <= stb_d;
      div_q   <= div_d;
    end
  end

  // Outputs from flops
  assign link.sdo              = sdo_q;
  assign link.sdo_oe           = oe_q;
  assign link.ready_strobe_out = stb_q;
  assign input_shift_word      = isw_q;
  assign cmd_valid             = cmdv_q;
  assign input_config_reg      = icfg_q;
  assign output_config_reg     = ocfg_q;
endmodule

// ===== verilog/amsp_host.sv
// Host controller end: APB registers driving serial frames
module amsp_host
#(
  parameter int HALF = amsp_pkg::HALF_CYC   // Cycles per sclk half period
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  amsp_if.host             link
);
  // Frame sequencer states
  typedef enum logic [3:0]
  {
    HS_IDLE = 4'h1,
    HS_LEAD = 4'h2,
    HS_RUN  = 4'h4,
    HS_TAIL = 4'h8
  } amsp_hst_e;

  amsp_hst_e   st_q, st_d;
  logic [13:0] ctrl_q, ctrl_d;     // Protocol, lanes, src, clocks
  logic [19:0] tx_q, tx_d;         // Command to send
  logic [19:0] rx_q, rx_d;         // Received word
  logic [4:0]  ncap_q, ncap_d;     // Bits captured
  logic [7:0]  tmr_q, tmr_d;       // Half period timer
  logic [6:0]  edg_q, edg_d;       // Edges left
  logic [5:0]  brem_q, brem_d;     // Bits left to send
  logic        cs_q, cs_d;
  logic        sclk_q, sclk_d;
  logic        sdi_q, sdi_d;
  logic        sv_q;               // Strobe history
  logic [31:0] rd_q, rd_d;
  // Decodes
  logic        wr, setup, hit, even, tick, capt, lanch, src_cap;
  logic [1:0]  proto, lanes;
  logic [5:0]  nclk;

  // Next bit: leading zeros so last bits are the command
  function automatic logic nb(input logic [5:0] rem, input logic [19:0] w);
    logic b;
    b = 1'b0;
    if ((rem != 6'h00) && (rem <= 6'h14))
    begin
      b = w[5'(rem - 6'h01)];
    end
    return b;
  endfunction

  // Bus decode and field split
  always_comb
  begin
    wr    = psel & penable & pwrite;
    setup = psel & ~penable;
    hit   = (paddr == amsp_pkg::HA_CTRL) || (paddr == amsp_pkg::HA_TX) ||
            (paddr == amsp_pkg::HA_RX) || (paddr == amsp_pkg::HA_STAT);
    proto = ctrl_q[amsp_pkg::HC_PROTO_LO +: 2];
    lanes = ctrl_q[amsp_pkg::HC_LANE_LO +: 2];
    nclk  = ctrl_q[amsp_pkg::HC_NCLK_LO +: 6];
    even  = ~proto[0];
    tick  = (tmr_q == 8'(HALF - 1));
    capt    = (st_q == HS_RUN) & tick & (even ? ~edg_q[0] : edg_q[0]);
    lanch   = (st_q == HS_RUN) & tick & (even ? edg_q[0] : ~edg_q[0]);
    src_cap = ~cs_q & link.ready_strobe_out & ~sv_q;
  end

  // Register reads prepared in setup phase
  always_comb
  begin
    rd_d = rd_q;
    if (setup)
    begin
      case (paddr)
        amsp_pkg::HA_CTRL: rd_d = {18'h00000, ctrl_q};
        amsp_pkg::HA_TX:   rd_d = {12'h000, tx_q};
        amsp_pkg::HA_RX:   rd_d = {12'h000, rx_q};
        amsp_pkg::HA_STAT: rd_d = {31'h00000000, st_q != HS_IDLE};
        default:           rd_d = 32'h00000000;
      endcase
    end
  end

  // Sequencer and shift logic
  always_comb
  begin
    st_d   = st_q;
    ctrl_d = ctrl_q;
    tx_d   = tx_q;
    rx_d   = rx_q;
    ncap_d = ncap_q;
    tmr_d  = tick ? 8'h00 : tmr_q + 8'h01;
    edg_d  = edg_q;
    brem_d = brem_q;
    cs_d   = cs_q;
    sclk_d = sclk_q;
    sdi_d  = sdi_q;
    if (wr && (paddr == amsp_pkg::HA_CTRL) && (st_q == HS_IDLE))
    begin
      ctrl_d = pwdata[13:0];
      sclk_d = pwdata[amsp_pkg::HC_PROTO_LO + 1];
    end
    // Capture from lanes or strobe
    if ((capt && !ctrl_q[amsp_pkg::HC_SRC]) || (src_cap && ctrl_q[amsp_pkg::HC_SRC]))
    begin
      if (ncap_q < 5'h14)
      begin
        case (lanes)
          amsp_pkg::LANE_DUAL: rx_d = {rx_q[17:0], link.sdo[0], link.sdo[1]};
          amsp_pkg::LANE_QUAD: rx_d = {rx_q[15:0], link.sdo[0], link.sdo[1], link.sdo[2], link.sdo[3]};
          default:             rx_d = {rx_q[18:0], link.sdo[0]};
        endcase
        ncap_d = ncap_q + ((lanes == amsp_pkg::LANE_QUAD) ? 5'h04 :
                           (lanes == amsp_pkg::LANE_DUAL) ? 5'h02 : 5'h01);
      end
    end
    case (st_q)
      HS_IDLE:
      begin
        tmr_d = 8'h00;
        if (wr && (paddr == amsp_pkg::HA_TX))
        begin
          tx_d   = pwdata[19:0];
          rx_d   = 20'h00000;
          ncap_d = 5'h00;
          cs_d   = 1'b0;
          edg_d  = {nclk, 1'b0};
          brem_d = nclk;
          sdi_d  = 1'b0;
          if (even)
          begin
            sdi_d  = nb(nclk, pwdata[19:0]);
            brem_d = (nclk == 6'h00) ? 6'h00 : nclk - 6'h01;
          end
          st_d = HS_LEAD;
        end
      end
      HS_LEAD:
      begin
        if (tick)
        begin
          st_d = (edg_q == 7'h00) ? HS_TAIL : HS_RUN;
        end
      end
      HS_RUN:
      begin
        if (tick)
        begin
          sclk_d = ~sclk_q;
          edg_d  = edg_q - 7'h01;
          if (lanch && (brem_q != 6'h00))
          begin
            sdi_d  = nb(brem_q, tx_q);
            brem_d = brem_q - 6'h01;
          end
          if (edg_q == 7'h01)
          begin
            st_d = HS_TAIL;
          end
        end
      end
      HS_TAIL:
      begin
        if (tick)
        begin
          cs_d = 1'b1;
          st_d = HS_IDLE;
        end
      end
      default:
      begin
        st_d = HS_IDLE;
      end
    endcase
  end

  // Host registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q   <= HS_IDLE;
      ctrl_q <= 14'h0000;
      tx_q   <= 20'h00000;
      rx_q   <= 20'h00000;
      ncap_q <= 5'h00;
      tmr_q  <= 8'h00;
      edg_q  <= 7'h00;
      brem_q <= 6'h00;
      cs_q   <= 1'b1;
      sclk_q <= 1'b0;
      sdi_q  <= 1'b0;
      sv_q   <= 1'b1;
      rd_q   <= 32'h00000000;
    end
    else
    begin
      st_q   <= st_d;
      ctrl_q <= ctrl_d;
      tx_q   <= tx_d;
      rx_q   <= rx_d;
      ncap_q <= ncap_d;
      tmr_q  <= tmr_d;
      edg_q  <= edg_d;
      brem_q <= brem_d;
      cs_q   <= cs_d;
      sclk_q <= sclk_d;
      sdi_q  <= sdi_d;
      sv_q   <= link.ready_strobe_out;
      rd_q   <= rd_d;
    end
  end

  // Bus answers and pins
  assign prdata    = rd_q;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~hit;
  assign link.cs_n = cs_q;
  assign link.sclk = sclk_q;
  assign link.sdi  = sdi_q;
endmodule

// ===== test/amsp_checker.sv
// Concurrent checks on the link between host and converter ends
module amsp_checker
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        cs_n,
  input wire logic        sclk,
  input wire logic [3:0]  sdo_oe,
  input wire logic        ready_strobe_out,
  input wire logic        cmd_valid,
  input wire logic [19:0] input_shift_word,
  input wire logic [7:0]  input_config_reg,
  input wire logic [7:0]  output_config_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_rst_idle;
    $fell(srst) |-> cs_n && !sclk && sdo_oe == 4'h0 && ready_strobe_out
      && input_config_reg == 8'h00 && output_config_reg == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");

  property p_spi_low;
    (!cs_n && output_config_reg[1:0] == amsp_pkg::MODE_SPI) [*4] |-> !ready_strobe_out;
  endproperty
  a_spi_low: assert property (p_spi_low) else $error("strobe high in host clocked frame");

  property p_oe_one;
    (!cs_n && output_config_reg[3:2] == 2'h0) [*4] |-> sdo_oe == 4'h1;
  endproperty
  a_oe_one: assert property (p_oe_one) else $error("single lane enables wrong");

  property p_oe_dual;
    (!cs_n && output_config_reg[3:2] == amsp_pkg::LANE_DUAL) [*4] |-> sdo_oe == 4'h3;
  endproperty
  a_oe_dual: assert property (p_oe_dual) else $error("dual lane enables wrong");

  property p_oe_quad;
    (!cs_n && output_config_reg[3:2] == amsp_pkg::LANE_QUAD) [*4] |-> sdo_oe == 4'hf;
  endproperty
  a_oe_quad: assert property (p_oe_quad) else $error("quad lane enables wrong");

  property p_oe_off;
    $rose(cs_n) |-> ##[1:3] sdo_oe == 4'h0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("lanes still driven after deselect");

  property p_src_strobe;
    $fell(cs_n) && output_config_reg[1:0] == amsp_pkg::MODE_SRC |-> ##[1:40] $rose(ready_strobe_out);
  endproperty
  a_src_strobe: assert property (p_src_strobe) else $error("no strobe edge in frame");

  property p_cmd_at_end;
    cmd_valid |-> cs_n && !($past(cs_n, 2) && $past(cs_n, 3) && $past(cs_n, 4) && $past(cs_n, 5));
  endproperty
  a_cmd_at_end: assert property (p_cmd_at_end) else $error("command pulse away from frame end");

  property p_icfg_write;
    $rose(cmd_valid) |-> ##[0:2] (input_shift_word[19:8] != {amsp_pkg::OP_WR, amsp_pkg::REG_ICFG}
      || input_config_reg[1:0] == input_shift_word[1:0]);
  endproperty
  a_icfg_write: assert property (p_icfg_write) else $error("input protocol not updated");

  property p_cfg_hold;
    !cs_n |-> $stable(output_config_reg) && $stable(input_config_reg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed inside frame");

  property p_cfg_cause;
    !$stable(input_config_reg) || !$stable(output_config_reg)
      |-> cmd_valid || $past(cmd_valid) || $past(cmd_valid, 2);
  endproperty
  a_cfg_cause: assert property (p_cfg_cause) else $error("config changed without command");
endmodule

// ===== test/adc_multilane_serial_port_test.sv
// Bench joining host and converter ends over the link
module adc_multilane_serial_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;               // 125 MHz clock
  logic        srst;              // Synchronous reset
  logic        psel;              // APB select
  logic        penable;           // APB enable
  logic        pwrite;            // APB direction
  logic [11:0] paddr;             // APB address
  logic [31:0] pwdata;            // APB write data
  logic [31:0] prdata;            // APB read data
  logic        pready;            // APB ready
  logic        pslverr;           // APB error
  logic [19:0] result;            // Word offered by converter
  logic [19:0] input_shift_word;  // Last accepted command
  logic        cmd_valid;         // Command pulse
  logic [7:0]  input_config_reg;  // Device input protocol
  logic [7:0]  output_config_reg; // Device output setup
  logic [1:0]  h_proto;           // Host protocol field
  logic [1:0]  h_lanes;           // Host lane field
  logic        h_src;             // Host strobe capture
  int          fail_count;        // Mismatches
  int          comparisons;       // Comparisons made
  logic [3:0]  tail_sdo;          // Lanes seen at frame end

  amsp_if amsp_if_i ();
  amsp_dev amsp_dev_i (.clk(clk), .srst(srst), .result(result), .input_shift_word(input_shift_word),
    .cmd_valid(cmd_valid), .input_config_reg(input_config_reg), .output_config_reg(output_config_reg),
    .link(amsp_if_i.dev));
  amsp_host amsp_host_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(amsp_if_i.host));
  amsp_checker amsp_checker_i (.clk(clk), .srst(srst), .cs_n(amsp_if_i.cs_n), .sclk(amsp_if_i.sclk),
    .sdo_oe(amsp_if_i.sdo_oe), .ready_strobe_out(amsp_if_i.ready_strobe_out), .cmd_valid(cmd_valid),
    .input_shift_word(input_shift_word), .input_config_reg(input_config_reg),
    .output_config_reg(output_config_reg));

  // Free-running clock
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Compare one value and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait ran out
  task automatic give_up(input string what);
    fail_count++;
    $display("mismatch at %0t: timeout in %s", $time, what);
    summarize();
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      give_up("apb");
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait for chip select level
  task automatic wait_cs(input logic lvl, input int lim);
    int k;
    k = 0;
    while (amsp_if_i.cs_n !== lvl)
    begin
      @(negedge clk);
      tail_sdo = amsp_if_i.sdo;
      k++;
      if (k > lim)
        give_up("frame");
    end
  endtask

  // Host frame of n clocks; reports command pulse and received word
  task automatic frame(input logic [5:0] n, input logic [19:0] cmd, input logic [19:0] v,
                       output logic seen, output logic [31:0] rx);
    logic [31:0] q;
    logic        e;
    @(posedge clk);
    result <= v;
    apb(1'b1, amsp_pkg::HA_CTRL, {18'h0, n, 3'h0, h_src, h_lanes, h_proto}, q, e);
    apb(1'b1, amsp_pkg::HA_TX, {12'h0, cmd}, q, e);
    wait_cs(1'b0, 20);
    wait_cs(1'b1, 2000);
    seen = 1'b0;
    repeat (10)
    begin
      @(negedge clk);
      seen = seen | (cmd_valid === 1'b1);
    end
    apb(1'b0, amsp_pkg::HA_STAT, 32'h0, q, e);
    check(q[0], 1'b0, "busy after frame");
    apb(1'b0, amsp_pkg::HA_RX, 32'h0, rx, e);
  endtask

  // Reset held six cycles
  task automatic do_reset();
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check({amsp_if_i.cs_n, amsp_if_i.ready_strobe_out, amsp_if_i.sdo_oe, input_config_reg, output_config_reg},
      {2'h3, 20'h0}, "reset state");
    h_proto = amsp_pkg::PROTO_00;
    h_lanes = 2'h0;
    h_src   = 1'b0;
  endtask

  // Unmapped host address refused
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    apb(1'b0, 12'h010, 32'h0, q, e);
    check(q, 32'h0, "unmapped data");
    check(e, 1'b1, "unmapped error");
  endtask

  // Short frame then long frame
  task automatic t_frames();
    logic        s;
    logic [31:0] rx;
    frame(6'd19, {amsp_pkg::OP_WR, amsp_pkg::REG_ICFG, 8'h03}, 20'h9a5a5, s, rx);
    check(s, 1'b0, "short frame pulse");
    check({input_shift_word, input_config_reg}, 28'h0, "short frame state");
    frame(6'd24, {amsp_pkg::OP_WR, amsp_pkg::REG_ICFG, 8'h00}, 20'h3c00f, s, rx);
    check(input_shift_word, {amsp_pkg::OP_WR, amsp_pkg::REG_ICFG, 8'h00}, "last bits");
    check(rx, 32'h3c00f, "daisy read");
  endtask

  // Every input protocol: switch, then read with it
  task automatic t_protos();
    logic        s;
    logic [1:0]  p;
    logic [31:0] rx;
    for (int i = 1; i < 5; i++)
    begin
      p = 2'(i);
      frame(6'd20, {amsp_pkg::OP_WR, amsp_pkg::REG_ICFG, 6'h0, p}, 20'h0, s, rx);
      check(s, 1'b1, "write pulse");
      check(input_config_reg, {6'h0, p}, "input protocol");
      h_proto = p;
      frame(6'd20, 20'h0, {6'h20, p, 12'h00d}, s, rx);
      check(rx, {12'h0, 6'h20, p, 12'h00d}, "protocol read");
    end
  endtask

  // Dual and quad read-out with fewer clocks
  task automatic t_lanes();
    logic        s;
    logic [1:0]  w;
    logic [31:0] rx;
    for (int i = 0; i < 2; i++)
    begin
      w = i ? amsp_pkg::LANE_QUAD : amsp_pkg::LANE_DUAL;
      frame(6'd20, {amsp_pkg::OP_WR, amsp_pkg::REG_OCFG, 4'h0, w, amsp_pkg::MODE_SPI}, 20'h0, s, rx);
      check(output_config_reg, {4'h0, w, amsp_pkg::MODE_SPI}, "width setup");
      h_lanes = w;
      frame(i ? 6'd5 : 6'd10, 20'h0, {w, 18'h2c3a5}, s, rx);
      check(rx, {12'h0, w, 18'h2c3a5}, "lane read");
    end
    frame(6'd20, {amsp_pkg::OP_WR, amsp_pkg::REG_OCFG, 8'h00}, 20'h0, s, rx);
    check(output_config_reg, 8'h00, "write under quad");
    h_lanes = 2'h0;
  endtask

  // Every strobe origin in source-synchronous read-out
  task automatic t_src();
    logic        s;
    logic [7:0]  oc;
    logic [31:0] rx;
    for (int i = 0; i < 4; i++)
    begin
      oc = {2'(i), 4'h0, amsp_pkg::MODE_SRC};
      frame(6'd20, {amsp_pkg::OP_WR, amsp_pkg::REG_OCFG, oc}, 20'h0, s, rx);
      check(output_config_reg, oc, "strobe setup");
      h_src = 1'b1;
      frame(i ? 6'd48 : 6'd20, 20'h0, {12'hc35, oc}, s, rx);
      check(rx, {12'h0, 12'hc35, oc}, "strobe read");
      if (i > 0) check(tail_sdo, 4'h0, "zero fill");
      h_src = 1'b0;
    end
  endtask

  // Second reset restores default protocol
  task automatic t_rereset();
    logic        s;
    logic [31:0] rx;
    frame(6'd20, {amsp_pkg::OP_WR, amsp_pkg::REG_ICFG, 8'h02}, 20'h0, s, rx);
    check(input_config_reg, 8'h02, "before reset");
    do_reset();
    frame(6'd20, 20'h0, 20'h6b1e7, s, rx);
    check(rx, 32'h6b1e7, "default read");
  endtask

  // Main sequence
  initial
  begin
    srst        = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    result      = 20'h0;
    fail_count  = 0;
    comparisons = 0;
    do_reset();
    t_regs();
    t_frames();
    t_protos();
    t_lanes();
    t_src();
    t_rereset();
    summarize();
  end
endmodule
